// ==== verilog/rre_pkg.sv ====
package rre_pkg;
  // Instruction word and field layout
  localparam int INSTR_W = 14;
  localparam int PC_W = 15;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int DEST_BIT = 7;
  localparam int STACK_DEPTH = 16;
  localparam int STACK_AW = 4;

  // Opcodes as decoded by this block
  localparam logic [13:0] OP_RETURN = 14'h0008;
  localparam logic [13:0] OP_RET_INT = 14'h0009;
  localparam logic [5:0] OP_RET_LIT_HI = 6'h34;
  localparam logic [5:0] OP_ROT_LEFT_HI = 6'h0d;
  localparam logic [5:0] OP_ROT_RIGHT_HI = 6'h0c;

  // Instruction cycle counts
  localparam int RET_CYCLES = 2;
  localparam int ROT_CYCLES = 1;

  // Bit positions
  localparam int INT_ENABLE_BIT = 7;
  localparam int CARRY_BIT = 0;

  // Register offsets on the plain register port
  localparam int REG_AW = 3;
  localparam logic [2:0] OFS_WORK = 3'h0;
  localparam logic [2:0] OFS_STATUS = 3'h1;
  localparam logic [2:0] OFS_INTCTL = 3'h2;
  localparam logic [2:0] OFS_PC_LO = 3'h3;
  localparam logic [2:0] OFS_PC_HI = 3'h4;
  localparam logic [2:0] OFS_STKPTR = 3'h5;

  // Reset values
  localparam logic [7:0] RST_WORK = 8'h00;
  localparam logic [7:0] RST_INTCTL = 8'h00;
  localparam logic RST_CARRY = 1'h0;
  localparam logic [14:0] RST_PC = 15'h0000;
  localparam logic [3:0] RST_STKPTR = 4'h0;

  typedef enum logic
  {
    RRE_EXEC = 1'h0,
    RRE_FLUSH = 1'h1
  } rre_state_t;
endpackage

// ==== verilog/rre_stack_mem.sv ====
`timescale 1ns/1ns
module rre_stack_mem
#(
  parameter int WIDTH = 15,
  parameter int DEPTH = 16,
  parameter int AW = 4
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic [WIDTH-1:0] rd_data_out
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] rd_q;

  always_ff @(posedge clk_in)
  begin
    if (wr_en_in)
      mem_q[wr_addr_in] <= wr_data_in;
  end

  // Bypass so a push followed at once by a return sees the new entry
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      rd_q <= '0;
    else if (wr_en_in && wr_addr_in == rd_addr_in)
      rd_q <= wr_data_in;
    else
      rd_q <= mem_q[rd_addr_in];
  end

  assign rd_data_out = rd_q;
endmodule

// ==== verilog/rre_exec.sv ====
`timescale 1ns/1ns
module rre_exec
#(
  parameter int STACK_DEPTH = rre_pkg::STACK_DEPTH
)
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic instr_valid_in,
  input wire logic [13:0] instr_in,
  output logic instr_discard_out,
  input wire logic push_in,
  input wire logic [14:0] push_addr_in,
  output logic pc_load_out,
  output logic [14:0] pc_out,
  output logic [6:0] file_raddr_out,
  input wire logic [7:0] file_rdata_in,
  output logic file_we_out,
  output logic [6:0] file_waddr_out,
  output logic [7:0] file_wdata_out,
  output logic [7:0] work_out,
  output logic carry_out,
  output logic global_interrupt_enable_out,
  input wire logic [2:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out
);
  rre_pkg::rre_state_t state_q;
  rre_pkg::rre_state_t state_d;
  logic [7:0] w_q;
  logic carry_q;
  logic [7:0] interrupt_control_reg_q;
  logic [14:0] pc_q;
  logic pc_load_q;
  logic [3:0] sp_q;
  logic [3:0] sp_d;
  logic [14:0] stack_top_entry;
  logic file_we_q;
  logic [6:0] file_waddr_q;
  logic [7:0] file_wdata_q;
  logic [7:0] reg_rdata_q;
  logic exec;
  logic return_from_interrupt_op;
  logic return_with_literal_op;
  logic return_sub_op;
  logic rotate_left_carry_op;
  logic rotate_right_carry_op;
  logic any_return;
  logic rotate_any;
  logic dest_file;
  logic [7:0] rot_result;
  logic rot_carry;
  logic push_ok;

  // Decode only in an execute cycle; the flush cycle ignores the word
  assign exec = instr_valid_in && state_q == rre_pkg::RRE_EXEC;
  assign return_from_interrupt_op = exec && instr_in == rre_pkg::OP_RET_INT;
  assign return_sub_op = exec && instr_in == rre_pkg::OP_RETURN;
  assign return_with_literal_op = exec && instr_in[13:8] == rre_pkg::OP_RET_LIT_HI;
  assign rotate_left_carry_op = exec && instr_in[13:8] == rre_pkg::OP_ROT_LEFT_HI;
  assign rotate_right_carry_op = exec && instr_in[13:8] == rre_pkg::OP_ROT_RIGHT_HI;
  assign any_return = return_from_interrupt_op || return_sub_op || return_with_literal_op;
  assign rotate_any = rotate_left_carry_op || rotate_right_carry_op;
  assign dest_file = instr_in[rre_pkg::DEST_BIT];
  // File address is a read request, so it is combinational from the word
  assign file_raddr_out = instr_in[6:0];

  always_comb
  begin
    if (rotate_left_carry_op)
    begin
      rot_result = {file_rdata_in[6:0], carry_q};
      rot_carry = file_rdata_in[7];
    end
    else
    begin
      rot_result = {carry_q, file_rdata_in[7:1]};
      rot_carry = file_rdata_in[0];
    end
  end

  // Two-cycle returns: execute, then one flush cycle
  always_comb
  begin
    case (state_q)
      rre_pkg::RRE_EXEC:
        state_d = any_return ? rre_pkg::RRE_FLUSH : rre_pkg::RRE_EXEC;
      rre_pkg::RRE_FLUSH:
        state_d = rre_pkg::RRE_EXEC;
      default:
        state_d = rre_pkg::RRE_EXEC;
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      state_q <= rre_pkg::RRE_EXEC;
    else
      state_q <= state_d;
  end

  // A pop in the same cycle wins over an outside push
  assign push_ok = push_in && !any_return;

  always_comb
  begin
    if (any_return)
      sp_d = sp_q - 4'h1;
    else if (push_ok)
      sp_d = sp_q + 4'h1;
    else
      sp_d = sp_q;
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      sp_q <= rre_pkg::RST_STKPTR;
    else
      sp_q <= sp_d;
  end

  // Read address follows the next pointer so the top is ready a cycle later
  rre_stack_mem #(
    .WIDTH(rre_pkg::PC_W),
    .DEPTH(STACK_DEPTH),
    .AW(rre_pkg::STACK_AW)
  ) u_stack (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .wr_en_in(push_ok),
    .wr_addr_in(sp_q),
    .wr_data_in(push_addr_in),
    .rd_addr_in(sp_d - 4'h1),
    .rd_data_out(stack_top_entry)
  );

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      pc_q <= rre_pkg::RST_PC;
      pc_load_q <= 1'h0;
    end
    else
    begin
      pc_load_q <= any_return;
      if (any_return)
        pc_q <= stack_top_entry;
    end
  end

  // Instruction writes to W beat a software write in the same cycle
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      w_q <= rre_pkg::RST_WORK;
    else if (return_with_literal_op)
      w_q <= instr_in[7:0];
    else if (rotate_any && !dest_file)
      w_q <= rot_result;
    else if (reg_wr_in && reg_addr_in == rre_pkg::OFS_WORK)
      w_q <= reg_wdata_in;
  end

  // Only rotates and status writes touch carry, a rotate winning; returns leave it alone
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      carry_q <= rre_pkg::RST_CARRY;
    else if (rotate_any)
      carry_q <= rot_carry;
    else if (reg_wr_in && reg_addr_in == rre_pkg::OFS_STATUS)
      carry_q <= reg_wdata_in[rre_pkg::CARRY_BIT];
  end

  // Set by the return beats a clear from software
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      interrupt_control_reg_q <= rre_pkg::RST_INTCTL;
    else
    begin
      if (reg_wr_in && reg_addr_in == rre_pkg::OFS_INTCTL)
        interrupt_control_reg_q <= reg_wdata_in;
      if (return_from_interrupt_op)
        interrupt_control_reg_q[rre_pkg::INT_ENABLE_BIT] <= 1'h1;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      file_we_q <= 1'h0;
      file_waddr_q <= 7'h00;
      file_wdata_q <= 8'h00;
    end
    else
    begin
      file_we_q <= rotate_any && dest_file;
      if (rotate_any && dest_file)
      begin
        file_waddr_q <= instr_in[6:0];
        file_wdata_q <= rot_result;
      end
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      reg_rdata_q <= 8'h00;
    else if (!reg_rd_in)
      reg_rdata_q <= 8'h00;
    else
    begin
      case (reg_addr_in)
        rre_pkg::OFS_WORK: reg_rdata_q <= w_q;
        rre_pkg::OFS_STATUS: reg_rdata_q <= {7'h00, carry_q};
        rre_pkg::OFS_INTCTL: reg_rdata_q <= interrupt_control_reg_q;
        rre_pkg::OFS_PC_LO: reg_rdata_q <= pc_q[7:0];
        rre_pkg::OFS_PC_HI: reg_rdata_q <= {1'h0, pc_q[14:8]};
        rre_pkg::OFS_STKPTR: reg_rdata_q <= {4'h0, sp_q};
        default: reg_rdata_q <= 8'h00;
      endcase
    end
  end

  assign instr_discard_out = state_q == rre_pkg::RRE_FLUSH;
  assign pc_load_out = pc_load_q;
  assign pc_out = pc_q;
  assign file_we_out = file_we_q;
  assign file_waddr_out = file_waddr_q;
  assign file_wdata_out = file_wdata_q;
  assign work_out = w_q;
  assign carry_out = carry_q;
  assign global_interrupt_enable_out = interrupt_control_reg_q[rre_pkg::INT_ENABLE_BIT];
  assign reg_rdata_out = reg_rdata_q;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  // A software status write in the same cycle may legally move carry
  chk_int_return: assert property (
    return_from_interrupt_op && !reg_wr_in |=> pc_load_out && pc_out == $past(stack_top_entry) && instr_discard_out
      && carry_out == $past(carry_q) ##1 !instr_discard_out)
  else $error("return from interrupt did not reload pc in two cycles");

  chk_enable_bit_seven: assert property (
    return_from_interrupt_op |=> interrupt_control_reg_q[7] && global_interrupt_enable_out)
  else $error("interrupt enable bit 7 not set");

  chk_literal_return: assert property (
    return_with_literal_op && !reg_wr_in |=> w_q == $past(instr_in[7:0]) && pc_out == $past(stack_top_entry)
      && carry_out == $past(carry_q) && instr_discard_out)
  else $error("literal return wrong");

  chk_sub_return_pop: assert property (
    return_sub_op |=> sp_q == $past(sp_q) - 4'h1 && pc_out == $past(stack_top_entry) && instr_discard_out
      ##1 !instr_discard_out)
  else $error("subroutine return did not pop");

  chk_rotate_left_val: assert property (
    rotate_left_carry_op |=> carry_out == $past(file_rdata_in[7])
      && (work_out == {$past(file_rdata_in[6:0]), $past(carry_q)}
      || file_wdata_out == {$past(file_rdata_in[6:0]), $past(carry_q)}))
  else $error("rotate left result wrong");

  chk_rotate_left_dest: assert property (
    rotate_left_carry_op && instr_in[7] && !reg_wr_in |=> file_we_out && file_waddr_out == $past(instr_in[6:0])
      && work_out == $past(w_q))
  else $error("rotate left destination wrong");

  chk_rotate_one_cycle: assert property (
    rotate_left_carry_op && !reg_wr_in && !push_in |=> !instr_discard_out
      && interrupt_control_reg_q == $past(interrupt_control_reg_q) && sp_q == $past(sp_q))
  else $error("rotate left not single cycle");

  chk_rotate_right_val: assert property (
    rotate_right_carry_op && !instr_in[7] && !reg_wr_in |=> !file_we_out
      && work_out == {$past(carry_q), $past(file_rdata_in[7:1])} && carry_out == $past(file_rdata_in[0]))
  else $error("rotate right result wrong");

  chk_flush_discards: assert property (
    instr_discard_out && instr_valid_in && !reg_wr_in |=> !file_we_out && !pc_load_out
      && work_out == $past(w_q) && carry_out == $past(carry_q))
  else $error("prefetched instruction executed in flush cycle");
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/1ns
module testbench;
  logic clk_in = 1'h0;
  logic reset_n_in = 1'h0;
  logic instr_valid_in = 1'h0;
  logic [13:0] instr_in = 14'h0000;
  logic push_in = 1'h0;
  logic [14:0] push_addr_in = 15'h0000;
  logic [7:0] file_rdata_in = 8'h00;
  logic [2:0] reg_addr_in = 3'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'h0;
  logic reg_rd_in = 1'h0;
  logic instr_discard_out;
  logic pc_load_out;
  logic [14:0] pc_out;
  logic [6:0] file_raddr_out;
  logic file_we_out;
  logic [6:0] file_waddr_out;
  logic [7:0] file_wdata_out;
  logic [7:0] work_out;
  logic carry_out;
  logic global_interrupt_enable_out;
  logic [7:0] reg_rdata_out;
  logic [7:0] rd;
  int n_mismatch = 0;
  int compares = 0;

  rre_exec u_rre_exec
  (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .instr_valid_in(instr_valid_in), .instr_in(instr_in),
    .instr_discard_out(instr_discard_out), .push_in(push_in), .push_addr_in(push_addr_in),
    .pc_load_out(pc_load_out), .pc_out(pc_out), .file_raddr_out(file_raddr_out),
    .file_rdata_in(file_rdata_in), .file_we_out(file_we_out), .file_waddr_out(file_waddr_out),
    .file_wdata_out(file_wdata_out), .work_out(work_out), .carry_out(carry_out),
    .global_interrupt_enable_out(global_interrupt_enable_out), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out)
  );

  initial
  begin
    forever #20 clk_in = ~clk_in;
  end

  task automatic summarize;
    $display("TB counts: compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk1(input string name, input logic e, input logic g);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic chk8(input string name, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic chk15(input string name, input logic [14:0] e, input logic [14:0] g);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'h1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'h0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_in);
    reg_rd_in <= 1'h1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'h0;
    #1;
    d = reg_rdata_out;
  endtask

  task automatic push(input logic [14:0] a);
    @(posedge clk_in);
    push_in <= 1'h1;
    push_addr_in <= a;
    @(posedge clk_in);
    push_in <= 1'h0;
  endtask

  // Hold keeps a follow-up word valid in the flush cycle; caller then calls step or idle
  task automatic step(input logic [13:0] w, input logic [7:0] f, input logic hold, input logic [13:0] nxt);
    @(posedge clk_in);
    instr_valid_in <= 1'h1;
    instr_in <= w;
    file_rdata_in <= f;
    @(posedge clk_in);
    if (hold)
      instr_in <= nxt;
    else
      instr_valid_in <= 1'h0;
    #1;
  endtask

  task automatic idle;
    @(posedge clk_in);
    instr_valid_in <= 1'h0;
    #1;
  endtask

  initial
  begin
    #(40 * 3000);
    n_mismatch++;
    summarize();
  end

  initial
  begin
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'h1;
    chk1("carry reset", 1'h0, carry_out);
    for (int i = 0; i < 8; i++)
    begin
      reg_read(i[2:0], rd);
      chk8("reset register", 8'h00, rd);
    end
    step(14'h0d05, 8'he6, 1'h0, 14'h0000);
    chk8("file read addr", 8'h05, {1'h0, file_raddr_out});
    chk8("rotl work", 8'hcc, work_out);
    chk1("rotl carry", 1'h1, carry_out);
    chk1("rotl no file write", 1'h0, file_we_out);
    step(14'h0dff, 8'h80, 1'h0, 14'h0000);
    chk1("rotl file write", 1'h1, file_we_out);
    chk8("rotl write addr", 8'h7f, {1'h0, file_waddr_out});
    chk8("rotl write data", 8'h01, file_wdata_out);
    chk8("rotl work kept", 8'hcc, work_out);
    chk1("rotl carry msb", 1'h1, carry_out);
    idle();
    chk1("write pulse ends", 1'h0, file_we_out);
    step(14'h0c05, 8'h01, 1'h0, 14'h0000);
    chk8("rotr work", 8'h80, work_out);
    chk1("rotr carry", 1'h1, carry_out);
    step(14'h0c80, 8'h02, 1'h0, 14'h0000);
    chk8("rotr write data", 8'h81, file_wdata_out);
    chk8("rotr write addr", 8'h00, {1'h0, file_waddr_out});
    chk1("rotr carry lsb", 1'h0, carry_out);
    chk8("rotr work kept", 8'h80, work_out);
    reg_write(3'h2, 8'h40);
    reg_write(3'h1, 8'h01);
    reg_write(3'h7, 8'hff);
    reg_read(3'h7, rd);
    chk8("unmapped read", 8'h00, rd);
    chk1("carry via status", 1'h1, carry_out);
    push(15'h1234);
    push(15'h0abc);
    // Follow-up word would rotate 0xff into W if the flush failed
    step(14'h0009, 8'hff, 1'h1, 14'h0d00);
    chk1("reti pc load", 1'h1, pc_load_out);
    chk15("reti pc", 15'h0abc, pc_out);
    chk1("reti discard", 1'h1, instr_discard_out);
    chk1("reti enable", 1'h1, global_interrupt_enable_out);
    idle();
    chk1("reti load pulse", 1'h0, pc_load_out);
    chk1("discard one cycle", 1'h0, instr_discard_out);
    chk8("flushed work", 8'h80, work_out);
    chk1("reti carry kept", 1'h1, carry_out);
    reg_read(3'h2, rd);
    chk8("intctl bit7", 8'hc0, rd);
    reg_read(3'h5, rd);
    chk8("stack pointer", 8'h01, rd);
    step(14'h34a5, 8'h00, 1'h0, 14'h0000);
    chk8("litret work", 8'ha5, work_out);
    chk15("litret pc", 15'h1234, pc_out);
    chk1("litret carry kept", 1'h1, carry_out);
    idle();
    reg_read(3'h3, rd);
    chk8("pc low", 8'h34, rd);
    reg_read(3'h4, rd);
    chk8("pc high", 8'h12, rd);
    push(15'h7fff);
    push(15'h0001);
    // Second return sits in the flush cycle and must not pop
    step(14'h0008, 8'h00, 1'h1, 14'h0008);
    chk15("return pc", 15'h0001, pc_out);
    chk1("return discard", 1'h1, instr_discard_out);
    idle();
    chk15("flush no reload", 15'h0001, pc_out);
    chk1("flush no load pulse", 1'h0, pc_load_out);
    step(14'h0008, 8'h00, 1'h0, 14'h0000);
    chk15("return pc second", 15'h7fff, pc_out);
    chk1("return carry kept", 1'h1, carry_out);
    chk8("return work kept", 8'ha5, work_out);
    idle();
    reg_read(3'h5, rd);
    chk8("stack empty", 8'h00, rd);
    // Reset in mid-run must clear state that the tests above have set
    push(15'h0155);
    @(posedge clk_in);
    reset_n_in <= 1'h0;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'h1;
    #1;
    chk8("work after reset", 8'h00, work_out);
    chk15("pc after reset", 15'h0000, pc_out);
    chk1("carry after reset", 1'h0, carry_out);
    chk1("enable after reset", 1'h0, global_interrupt_enable_out);
    reg_read(3'h5, rd);
    chk8("pointer after reset", 8'h00, rd);
    summarize();
  end
endmodule
